// File: uart_irq_defines.vh
// Register map, field positions, reset values and codes for the
// interrupt-enable, queue-control and interrupt-status logic of one channel.
// Assumes an APB slave with 32-bit data, one register per aligned word.
//
// Summary of operation
// - Interrupt-enable register, low four bits gate sources, reset 0x0C, hidden when divisor selected.
// - Enable bit 0 gates the receiver-ready interrupt.
// - Enable bit 1 gates the transmitter-ready interrupt.
// - Enable bit 2 gates the receiver-status interrupt.
// - Enable bit 3 gates the modem-status-change interrupt.
// - Enable bit 4 selects sleep and gates the channel clock; bits 7:5 reserved.
// - Queue-control bit 0 picks byte or FIFO mode; any mode change flushes receive queue.
// - Writing 1 to queue-control bit 1 flushes receive queue in FIFO mode, self-clears.
// - Writing 1 to queue-control bit 2 flushes transmit queue likewise.
// - Queue-control bits 7:6 pick upper receive trigger 1, 4, 8 or 14.
// - Lower flow-control trigger is always 1, giving RTS/CTS hysteresis.
// - Byte mode forces every trigger level to 1.
// - Status register shows only highest-priority enabled pending source, shares offset 2.
// - Bit 0 is active-low pending; no interrupt reads 6'b000001.
// - Receiver status error or address bit: priority 1, code 6'b000110.
// - Data available 6'b000100 priority 2a; time-out 6'b001100 priority 2b.
// - Transmit empty 6'b000010 priority 3; modem change 6'b000000 priority 4.
// - Divisor-latch select maps offsets 0 and 1 to the divisor bytes.
`ifndef UART_IRQ_DEFINES_VH
`define UART_IRQ_DEFINES_VH

// ----------------------------------------------------------------------
// Byte addresses
// ----------------------------------------------------------------------
`define ADDR_DATA_DIVLO     8'h00
`define ADDR_IER_DIVHI      8'h04
`define ADDR_QCTRL_STATUS   8'h08
`define ADDR_LINE_FORMAT    8'h0C
`define ADDR_CHAN_STATE     8'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define IE_RX_READY         0
`define IE_TX_READY         1
`define IE_RX_STATUS        2
`define IE_MODEM            3
`define IE_SLEEP            4
`define QC_FIFO_EN          0
`define QC_FLUSH_RX         1
`define QC_FLUSH_TX         2
`define QC_TRIG_HI          7
`define QC_TRIG_LO          6
`define LF_DIV_SELECT       7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define IE_RESET            8'h0C
`define QC_RESET            8'h00
`define LF_RESET            8'h00
`define DIV_RESET           16'h0000

// ----------------------------------------------------------------------
// Status codes, low six bits
// ----------------------------------------------------------------------
`define ST_NONE             6'b000001
`define ST_RX_STATUS        6'b000110
`define ST_RX_DATA          6'b000100
`define ST_RX_TIMEOUT       6'b001100
`define ST_TX_EMPTY         6'b000010
`define ST_MODEM            6'b000000

// ----------------------------------------------------------------------
// Trigger levels and timing
// ----------------------------------------------------------------------
`define TRIG_1              5'h01
`define TRIG_4              5'h04
`define TRIG_8              5'h08
`define TRIG_14             5'h0E
`define FLUSH_CYCLES        2'h2

`endif

// File: uart_irq_prio.v
// Priority encoder for the channel's interrupt sources.
// Assumes source levels already gated by their enable bits.
`timescale 1ns/1ps
`include "uart_irq_defines.vh"

module uart_irq_prio (
    // Gated sources
    input  wire       rx_status,
    input  wire       rx_data,
    input  wire       rx_timeout,
    input  wire       tx_empty,
    input  wire       modem,
    // Encoded result
    output reg  [5:0] code,
    output wire       any
);

    assign any = rx_status | rx_data | rx_timeout | tx_empty | modem;

    always @* begin
        if (rx_status) begin
            code = `ST_RX_STATUS;
        end else if (rx_data) begin
            code = `ST_RX_DATA;
        end else if (rx_timeout) begin
            code = `ST_RX_TIMEOUT;
        end else if (tx_empty) begin
            code = `ST_TX_EMPTY;
        end else if (modem) begin
            code = `ST_MODEM;
        end else begin
            code = `ST_NONE;
        end
    end

endmodule // uart_irq_prio

// File: uart_irq_fifo_control.v
// Interrupt enable, queue control and interrupt status for one channel.
// Assumes APB master on CLOCK; source levels arrive synchronous to CLOCK
// and are cleared by the datapath when software services them.
`timescale 1ns/1ps
`include "uart_irq_defines.vh"

module uart_irq_fifo_control (
    // Clock and reset
    input  wire        CLOCK,
    input  wire        RST_B,
    // APB slave
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [7:0]  PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output wire        PREADY,
    output wire        PSLVERR,
    // Interrupt source levels from the datapath
    input  wire        RX_STATUS_ERR,
    input  wire        RX_DATA_AVAIL,
    input  wire        RX_TIMEOUT,
    input  wire        TX_HOLD_EMPTY,
    input  wire        MODEM_CHANGE,
    // Receive queue occupancy and holding byte
    input  wire [4:0]  RX_COUNT,
    input  wire [7:0]  RX_BYTE,
    // Queue control outputs
    output reg         FIFO_MODE,
    output reg         RX_FLUSH,
    output reg         TX_FLUSH,
    output reg  [4:0]  UPPER_TRIGGER,
    output reg  [4:0]  LOWER_TRIGGER,
    output reg         RX_TRIGGER_HIT,
    output reg         RTS_ALLOW,
    // Transmit write strobe and data, receive read strobe
    output reg         TX_WRITE,
    output reg  [7:0]  TX_BYTE,
    output reg         RX_READ,
    // Divisor and sleep
    output reg  [15:0] BAUD_DIVISOR,
    output reg         SLEEP,
    output reg         CHAN_CLK_EN,
    // Interrupt request
    output reg         IRQ
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    reg  [7:0]  interrupt_enable_r;
    reg  [7:0]  line_format_control_r;
    reg  [1:0]  trig_sel_r;
    reg         fifo_mode_r;
    reg  [1:0]  rx_flush_cnt_r;
    reg  [1:0]  tx_flush_cnt_r;
    reg  [7:0]  div_lo_r;
    reg  [7:0]  div_hi_r;
    reg  [7:0]  status_r;

    wire        wr_en;
    wire        rd_en;
    wire        divisor_latch_select;
    wire [5:0]  code;
    wire        any_pending;
    wire        mode_change;
    wire        rx_flush_req;
    wire        tx_flush_req;
    reg  [4:0]  upper_nxt;

    assign PREADY  = 1'b1;
    assign PSLVERR = 1'b0;
    assign wr_en = PSEL & PENABLE & PWRITE;
    assign rd_en = PSEL & PENABLE & ~PWRITE;
    assign divisor_latch_select = line_format_control_r[`LF_DIV_SELECT];

    function is_addr;
        input [7:0] a;
        input [7:0] b;
        begin
            is_addr = (a == b);
        end
    endfunction

    // ------------------------------------------------------------------
    // Source gating and priority
    // ------------------------------------------------------------------
    uart_irq_prio u_prio (
        .rx_status  (RX_STATUS_ERR & interrupt_enable_r[`IE_RX_STATUS]),
        .rx_data    (RX_DATA_AVAIL & interrupt_enable_r[`IE_RX_READY]),
        .rx_timeout (RX_TIMEOUT    & interrupt_enable_r[`IE_RX_READY]),
        .tx_empty   (TX_HOLD_EMPTY & interrupt_enable_r[`IE_TX_READY]),
        .modem      (MODEM_CHANGE  & interrupt_enable_r[`IE_MODEM]),
        .code       (code),
        .any        (any_pending)
    );

    // ------------------------------------------------------------------
    // Queue control decode
    // ------------------------------------------------------------------
    wire qc_write = wr_en & is_addr(PADDR, `ADDR_QCTRL_STATUS);
    wire new_mode = PWDATA[`QC_FIFO_EN];
    assign mode_change  = qc_write & (new_mode != fifo_mode_r);
    assign rx_flush_req = mode_change
                        | (qc_write & new_mode & PWDATA[`QC_FLUSH_RX]);
    assign tx_flush_req = qc_write & new_mode & PWDATA[`QC_FLUSH_TX];

    always @* begin
        case (trig_sel_r)
            2'b00:   upper_nxt = `TRIG_1;
            2'b01:   upper_nxt = `TRIG_4;
            2'b10:   upper_nxt = `TRIG_8;
            2'b11:   upper_nxt = `TRIG_14;
            default: upper_nxt = `TRIG_1;
        endcase
        if (!fifo_mode_r) begin
            upper_nxt = `TRIG_1;
        end
    end

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    always @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            interrupt_enable_r    <= `IE_RESET;
            line_format_control_r <= `LF_RESET;
            trig_sel_r            <= 2'b00;
            fifo_mode_r           <= 1'b0;
            div_lo_r              <= 8'h00;
            div_hi_r              <= 8'h00;
            rx_flush_cnt_r        <= 2'h0;
            tx_flush_cnt_r        <= 2'h0;
        end else begin
            if (wr_en && is_addr(PADDR, `ADDR_IER_DIVHI)) begin
                if (divisor_latch_select) begin
                    div_hi_r <= PWDATA[7:0];
                end else begin
                    interrupt_enable_r <= {3'b000, PWDATA[4:0]};
                end
            end
            if (wr_en && is_addr(PADDR, `ADDR_DATA_DIVLO) && divisor_latch_select) begin
                div_lo_r <= PWDATA[7:0];
            end
            if (wr_en && is_addr(PADDR, `ADDR_LINE_FORMAT)) begin
                line_format_control_r <= PWDATA[7:0];
            end
            if (qc_write) begin
                fifo_mode_r <= new_mode;
                trig_sel_r  <= PWDATA[`QC_TRIG_HI:`QC_TRIG_LO];
            end
            // Flush bits self-clear after a fixed clearing time
            if (rx_flush_req) begin
                rx_flush_cnt_r <= `FLUSH_CYCLES;
            end else if (rx_flush_cnt_r != 2'h0) begin
                rx_flush_cnt_r <= rx_flush_cnt_r - 2'h1;
            end
            if (tx_flush_req) begin
                tx_flush_cnt_r <= `FLUSH_CYCLES;
            end else if (tx_flush_cnt_r != 2'h0) begin
                tx_flush_cnt_r <= tx_flush_cnt_r - 2'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs from flip-flops
    // ------------------------------------------------------------------
    always @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            status_r       <= 8'h00;
            FIFO_MODE      <= 1'b0;
            RX_FLUSH       <= 1'b0;
            TX_FLUSH       <= 1'b0;
            UPPER_TRIGGER  <= `TRIG_1;
            LOWER_TRIGGER  <= `TRIG_1;
            RX_TRIGGER_HIT <= 1'b0;
            RTS_ALLOW      <= 1'b1;
            TX_WRITE       <= 1'b0;
            TX_BYTE        <= 8'h00;
            RX_READ        <= 1'b0;
            BAUD_DIVISOR   <= `DIV_RESET;
            SLEEP          <= 1'b0;
            CHAN_CLK_EN    <= 1'b1;
            IRQ            <= 1'b0;
        end else begin
            status_r      <= {{2{fifo_mode_r}}, code};
            FIFO_MODE     <= fifo_mode_r;
            RX_FLUSH      <= (rx_flush_cnt_r != 2'h0);
            TX_FLUSH      <= (tx_flush_cnt_r != 2'h0);
            UPPER_TRIGGER <= upper_nxt;
            LOWER_TRIGGER <= `TRIG_1;
            RX_TRIGGER_HIT <= (RX_COUNT >= upper_nxt);
            // Hysteresis: deassert at upper level, reassert at lower level
            if (RX_COUNT >= upper_nxt) begin
                RTS_ALLOW <= 1'b0;
            end else if (RX_COUNT < `TRIG_1 + 5'h01) begin
                RTS_ALLOW <= 1'b1;
            end
            TX_WRITE <= wr_en & is_addr(PADDR, `ADDR_DATA_DIVLO) & ~divisor_latch_select;
            if (wr_en && is_addr(PADDR, `ADDR_DATA_DIVLO) && !divisor_latch_select) begin
                TX_BYTE <= PWDATA[7:0];
            end
            RX_READ <= rd_en & is_addr(PADDR, `ADDR_DATA_DIVLO) & ~divisor_latch_select;
            BAUD_DIVISOR <= {div_hi_r, div_lo_r};
            SLEEP        <= interrupt_enable_r[`IE_SLEEP];
            CHAN_CLK_EN  <= ~interrupt_enable_r[`IE_SLEEP];
            IRQ          <= any_pending;
        end
    end

    // ------------------------------------------------------------------
    // Read mux; status reads the live code, not the registered copy
    // ------------------------------------------------------------------
    always @* begin
        PRDATA = 32'h0000_0000;
        case (PADDR)
            `ADDR_DATA_DIVLO:
                PRDATA[7:0] = divisor_latch_select ? div_lo_r : RX_BYTE;
            `ADDR_IER_DIVHI:
                PRDATA[7:0] = divisor_latch_select ? div_hi_r
                                                   : interrupt_enable_r;
            `ADDR_QCTRL_STATUS:
                PRDATA[7:0] = {{2{fifo_mode_r}}, code};
            `ADDR_LINE_FORMAT:
                PRDATA[7:0] = line_format_control_r;
            `ADDR_CHAN_STATE:
                PRDATA[7:0] = {3'b000, status_r[0], RX_FLUSH, TX_FLUSH,
                               ~RTS_ALLOW, fifo_mode_r};
            default:
                PRDATA = 32'h0000_0000;
        endcase
    end

endmodule // uart_irq_fifo_control

// File: uart_irq_fifo_control_sva.sv
// Concurrent checks on the interrupt, queue-control and status ports.
// Assumes one clock domain and binding onto the block's top ports.
`timescale 1ns/1ps
module uart_irq_chk (
    // Clock, reset and bus
    input wire logic        CLOCK, RST_B, PSEL, PENABLE, PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA, PRDATA,
    // Sources and control outputs
    input wire logic        RX_STATUS_ERR, RX_DATA_AVAIL, RX_TIMEOUT, TX_HOLD_EMPTY, MODEM_CHANGE,
    input wire logic [4:0]  RX_COUNT, UPPER_TRIGGER, LOWER_TRIGGER,
    input wire logic        FIFO_MODE, RX_FLUSH, TX_FLUSH, RTS_ALLOW, SLEEP, CHAN_CLK_EN, IRQ
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_B);
    wire qw   = PSEL && PENABLE && PWRITE && PADDR == 8'h08;
    wire qr   = PSEL && PENABLE && !PWRITE && PADDR == 8'h08;
    wire none = !(RX_STATUS_ERR | RX_DATA_AVAIL | RX_TIMEOUT | TX_HOLD_EMPTY | MODEM_CHANGE);
    property p_sleep; CHAN_CLK_EN == !SLEEP; endproperty
    a_sleep: assert property (p_sleep) else $error("clock enable follows sleep");
    property p_lower; LOWER_TRIGGER == 5'h01; endproperty
    a_lower: assert property (p_lower) else $error("lower level not one");
    property p_byte; !FIFO_MODE |-> UPPER_TRIGGER == 5'h01; endproperty
    a_byte: assert property (p_byte) else $error("byte mode level not one");
    // Mode bit lands in the register at the write edge, on the port one edge later
    property p_mode; qw |-> ##2 FIFO_MODE == $past(PWDATA[0], 2); endproperty
    a_mode: assert property (p_mode) else $error("mode bit not taken");
    property p_trig;
        qw && PWDATA[0] && PWDATA[7:6] == 2'b11 |-> ##2 UPPER_TRIGGER == 5'h0E;
    endproperty
    a_trig: assert property (p_trig) else $error("top trigger not fourteen");
    property p_mflush;
        qw && PWDATA[0] != FIFO_MODE |-> ##2 RX_FLUSH [*2] ##1 !RX_FLUSH;
    endproperty
    a_mflush: assert property (p_mflush) else $error("mode change without flush");
    property p_rflush;
        qw && PWDATA[0] && FIFO_MODE && PWDATA[1] |-> ##2 RX_FLUSH [*2] ##1 !RX_FLUSH;
    endproperty
    a_rflush: assert property (p_rflush) else $error("receive flush pulse wrong");
    property p_tflush;
        qw && PWDATA[0] && PWDATA[2] |-> ##2 TX_FLUSH [*2] ##1 !TX_FLUSH;
    endproperty
    a_tflush: assert property (p_tflush) else $error("transmit flush pulse wrong");
    property p_fbits; qr |-> PRDATA[7:6] == {2{FIFO_MODE}}; endproperty
    a_fbits: assert property (p_fbits) else $error("mode bits in status wrong");
    property p_idle; qr && none |-> PRDATA[5:0] == 6'b000001; endproperty
    a_idle: assert property (p_idle) else $error("idle status code wrong");
    property p_irq; none ##1 1'b1 |-> !IRQ; endproperty
    a_irq: assert property (p_irq) else $error("request without source");
    property p_rts; RX_COUNT >= UPPER_TRIGGER |=> !RTS_ALLOW; endproperty
    a_rts: assert property (p_rts) else $error("flow control not stopped");
    c_trig: cover property (qw && PWDATA[0] && PWDATA[7:6] == 2'b11);
    c_tflush: cover property (TX_FLUSH);
    c_irq: cover property (IRQ);
endmodule // uart_irq_chk

bind uart_irq_fifo_control uart_irq_chk u_chk (
    .CLOCK(CLOCK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .RX_STATUS_ERR(RX_STATUS_ERR),
    .RX_DATA_AVAIL(RX_DATA_AVAIL), .RX_TIMEOUT(RX_TIMEOUT), .TX_HOLD_EMPTY(TX_HOLD_EMPTY),
    .MODEM_CHANGE(MODEM_CHANGE), .RX_COUNT(RX_COUNT), .UPPER_TRIGGER(UPPER_TRIGGER),
    .LOWER_TRIGGER(LOWER_TRIGGER), .FIFO_MODE(FIFO_MODE), .RX_FLUSH(RX_FLUSH),
    .TX_FLUSH(TX_FLUSH), .RTS_ALLOW(RTS_ALLOW), .SLEEP(SLEEP), .CHAN_CLK_EN(CHAN_CLK_EN),
    .IRQ(IRQ));

// File: chan_src_model.sv
// Datapath stand-in: source levels, queue occupancy and holding byte.
// Assumes loads from the bench; a receive flush empties the queue.
`timescale 1ns/1ps
module chan_src_model #(parameter logic [7:0] RX_BYTE_VAL = 8'h5a) (
    input  wire logic       clock, rst_b, ld, rx_flush,
    input  wire logic [4:0] src_in, cnt_in,
    output logic      [4:0] src, cnt,
    output logic      [7:0] rx_byte
);
    assign rx_byte = RX_BYTE_VAL;
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            src <= 5'h00;
            cnt <= 5'h00;
        end else if (ld) begin
            src <= src_in;
            cnt <= cnt_in;
        end else if (rx_flush) begin
            // Emptied queue drops data-available too
            cnt    <= 5'h00;
            src[1] <= 1'b0;
        end
    end
endmodule // chan_src_model

// File: uart_irq_fifo_control_tb.sv
// Self-checking bench for the channel interrupt and queue-control block.
// Assumes a zero-wait APB slave and the datapath stand-in model.
`timescale 1ns/1ps
module uart_irq_fifo_control_tb;
    logic        CLOCK = 0, RST_B = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, ld = 0;
    logic [7:0]  PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0000_0000;
    logic [4:0]  src_in = 5'h00, cnt_in = 5'h00;
    wire  [31:0] PRDATA;
    wire  [15:0] BAUD_DIVISOR;
    wire  [7:0]  RX_BYTE, TX_BYTE;
    wire  [4:0]  src, RX_COUNT, UPPER_TRIGGER, LOWER_TRIGGER;
    wire         PREADY, FIFO_MODE, RX_FLUSH, TX_FLUSH, RX_TRIGGER_HIT, RTS_ALLOW, SLEEP;
    wire         CHAN_CLK_EN, IRQ, TX_WRITE, RX_READ;
    logic [31:0] q[$];
    int          fails = 0, num_checks = 0, i;
    logic [3:0]  e;
    logic [4:0]  s;
    logic [7:0]  c8;
    logic [4:0]  tbl[4] = '{5'h01, 5'h04, 5'h08, 5'h0E};

    uart_irq_fifo_control dut (.CLOCK(CLOCK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(), .RX_STATUS_ERR(src[0]), .RX_DATA_AVAIL(src[1]), .RX_TIMEOUT(src[2]),
        .TX_HOLD_EMPTY(src[3]), .MODEM_CHANGE(src[4]), .RX_COUNT(RX_COUNT), .RX_BYTE(RX_BYTE),
        .FIFO_MODE(FIFO_MODE), .RX_FLUSH(RX_FLUSH), .TX_FLUSH(TX_FLUSH),
        .UPPER_TRIGGER(UPPER_TRIGGER), .LOWER_TRIGGER(LOWER_TRIGGER),
        .RX_TRIGGER_HIT(RX_TRIGGER_HIT), .RTS_ALLOW(RTS_ALLOW), .TX_WRITE(TX_WRITE),
        .TX_BYTE(TX_BYTE), .RX_READ(RX_READ), .BAUD_DIVISOR(BAUD_DIVISOR), .SLEEP(SLEEP),
        .CHAN_CLK_EN(CHAN_CLK_EN),
        .IRQ(IRQ));
    chan_src_model model (.clock(CLOCK), .rst_b(RST_B), .ld(ld), .rx_flush(RX_FLUSH),
        .src_in(src_in), .cnt_in(cnt_in), .src(src), .cnt(RX_COUNT), .rx_byte(RX_BYTE));

    // ------------------------------------------------------------
    // Bus tasks and comparison
    // ------------------------------------------------------------
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLOCK);
        PSEL <= 1; PWRITE <= w; PADDR <= a; PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1;
        do @(posedge CLOCK); while (PREADY !== 1'b1);
        PSEL <= 0; PENABLE <= 0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1, a, {24'h00_0000, d});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        q.push_back(exp);
        apb(0, a, 32'h0000_0000);
    endtask
    // Lets register outputs of the last write land; caller samples afterwards
    task automatic settle;
        @(posedge CLOCK);
        #1;
    endtask
    task automatic load(input logic [4:0] sv, input logic [4:0] cv);
        @(posedge CLOCK);
        src_in <= sv; cnt_in <= cv; ld <= 1;
        @(posedge CLOCK);
        ld <= 0;
        repeat (2) @(posedge CLOCK);
    endtask
    function automatic logic [7:0] st(logic [4:0] sv, logic [3:0] ev, logic f);
        logic [5:0] c;
        if (sv[0] & ev[2]) c = 6'b000110;
        else if (sv[1] & ev[0]) c = 6'b000100;
        else if (sv[2] & ev[0]) c = 6'b001100;
        else if (sv[3] & ev[1]) c = 6'b000010;
        else if (sv[4] & ev[3]) c = 6'b000000;
        else c = 6'b000001;
        return {f, f, c};
    endfunction
    task automatic finish_test;
        $display("checks=%0d mismatches=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, monitor, watchdog, tests
    // ------------------------------------------------------------
    initial forever #12.5 CLOCK = ~CLOCK;
    always @(posedge CLOCK) begin
        if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE) begin
            if (q.size() == 0) begin
                fails++;
                $display("[ERR] t=%0t got=%h exp=%h", $time, PRDATA, 32'hxxxx_xxxx);
            end else cmp(PRDATA, q.pop_front());
        end
    end
    initial begin
        #(25 * 20000);
        fails++;
        finish_test;
    end
    initial begin
        void'($urandom(32'haf8f));
        repeat (3) @(posedge CLOCK);
        RST_B <= 1;
        rd(8'h04, 32'h0000_000C);
        rd(8'h08, 32'h0000_0001);
        settle;
        cmp({LOWER_TRIGGER, UPPER_TRIGGER}, 10'h021);
        wr(8'h04, 8'hFF);
        settle;
        cmp({SLEEP, CHAN_CLK_EN}, 2'b10);
        rd(8'h04, 32'h0000_001F);
        $display("test reset_enable done");
        for (i = 0; i < 4; i++) begin
            wr(8'h08, {i[1:0], 6'b000001});
            settle;
            cmp({RX_FLUSH, UPPER_TRIGGER}, {i == 0, tbl[i]});
            rd(8'h08, 32'h0000_00C1);
        end
        load(5'h00, 5'h0E);
        cmp({RX_TRIGGER_HIT, RTS_ALLOW}, 2'b10);
        load(5'h00, 5'h05);
        cmp({RX_TRIGGER_HIT, RTS_ALLOW}, 2'b00);
        load(5'h00, 5'h01);
        cmp({RX_TRIGGER_HIT, RTS_ALLOW}, 2'b01);
        wr(8'h08, 8'hC3);
        settle;
        cmp({RX_FLUSH, TX_FLUSH}, 2'b10);
        wr(8'h08, 8'hC5);
        settle;
        cmp({RX_FLUSH, TX_FLUSH}, 2'b01);
        wr(8'h08, 8'hC6);
        settle;
        cmp({FIFO_MODE, RX_FLUSH, TX_FLUSH, UPPER_TRIGGER}, 8'h41);
        $display("test queue_control done");
        for (i = 0; i < 24; i++) begin
            e = $urandom;
            s = $urandom;
            wr(8'h04, {4'h0, e});
            load(s, 5'h00);
            rd(8'h08, {24'h00_0000, st(s, e, 1'b0)});
            cmp(IRQ, st(s, e, 1'b0) != 8'h01);
        end
        $display("test priority done");
        wr(8'h0C, 8'h80);
        wr(8'h04, 8'h12);
        wr(8'h00, 8'h34);
        settle;
        cmp(BAUD_DIVISOR, 16'h1234);
        rd(8'h04, 32'h0000_0012);
        wr(8'h0C, 8'h00);
        rd(8'h04, {28'h000_0000, e});
        rd(8'h00, 32'h0000_005A);
        // Read strobe stands for one cycle after the access edge
        #1;
        cmp(RX_READ, 1'b1);
        wr(8'h00, 8'hA5);
        #1;
        cmp({TX_WRITE, TX_BYTE}, 9'h1A5);
        c8 = st(s, e, 1'b0);
        rd(8'h10, {27'h000_0000, c8[0], 4'h0});
        rd(8'h20, 32'h0000_0000);
        $display("test divisor done");
        finish_test;
    end
endmodule // uart_irq_fifo_control_tb
